// ---- rtl/aux_phy_pkg.sv ----
// constants shared by the auxiliary negotiation status register files
`default_nettype none
package aux_phy_pkg;
   // management address of the auxiliary status register
   localparam logic [4:0] REG_ADDR = 5'h1e;
   // bit positions of aux_phy_negotiation_status
   localparam int BIT_100_FDX = 15;
   localparam int BIT_T4 = 14;
   localparam int BIT_100_HDX = 13;
   localparam int BIT_10_FDX = 12;
   localparam int BIT_10_HDX = 11;
   localparam int BIT_RESTART = 8;
   localparam int BIT_COMPLETE = 7;
   localparam int BIT_ACK_DONE = 6;
   localparam int BIT_FIRST_ACK = 5;
   localparam int BIT_ABILITY = 4;
   localparam int BIT_DETACH = 3;
   localparam logic [15:0] REG_RESET = 16'h0000;
   // highest_common_ability mode codes from the negotiation machine
   localparam logic [1:0] HCD_10_HDX = 2'h0;
   localparam logic [1:0] HCD_10_FDX = 2'h1;
   localparam logic [1:0] HCD_100_HDX = 2'h2;
   localparam logic [1:0] HCD_100_FDX = 2'h3;
   localparam int HCD_COUNT = 4;
   // management frame layout
   localparam logic [5:0] MDIO_PREAMBLE_LEN = 6'h20;
   localparam logic [4:0] MDIO_START_COUNT = 5'h01;
   localparam logic [4:0] MDIO_HDR_LAST = 5'h0d;
   localparam logic [4:0] MDIO_TA_LEN = 5'h02;
   localparam logic [4:0] MDIO_RD_LAST = 5'h10;
   localparam logic [4:0] MDIO_WR_LAST = 5'h11;
   localparam logic [1:0] MDIO_ST = 2'h1;
   localparam logic [1:0] MDIO_OP_RD = 2'h2;
   localparam logic [1:0] MDIO_OP_WR = 2'h1;
   // delay from negotiation start to ability detect
   localparam int CLK_PERIOD_NS = 4;
   localparam int ABILITY_WAIT_NS = 1000;
   localparam int ABILITY_WAIT_CYCLES =
      (ABILITY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 8;
endpackage
`default_nettype wire

// ---- rtl/hcd_result_latch.sv ----
// sticky highest-common-ability result flags
`timescale 1ns/1ps
`default_nettype none
module hcd_result_latch (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic clear,
   input wire logic setValid,
   input wire logic [1:0] setMode,
   // flags, index is the mode code
   output logic [aux_phy_pkg::HCD_COUNT-1:0] flags
);
   genvar i;
   generate
      for (i = 0; i < aux_phy_pkg::HCD_COUNT; i++) begin : g_flag
         always_ff @(posedge clk) begin
            if (reset) begin
               flags[i] <= 1'b0;
            // set wins over clear
            end else if (setValid && setMode == 2'(i)) begin
               flags[i] <= 1'b1;
            end else if (clear) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- rtl/mdio_frame_slave.sv ----
// management serial frame slave answering one register address
`timescale 1ns/1ps
`default_nettype none
module mdio_frame_slave (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // management pins
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic [4:0] phyAddress,
   // register side
   input wire logic [15:0] readWord,
   output logic wrStrobe,
   output logic [15:0] wrData
);
   typedef enum logic [1:0] {
      MD_PREAMBLE = 2'b00,
      MD_HEADER = 2'b01,
      MD_READ = 2'b10,
      MD_WRITE = 2'b11
   } mdio_state_e;

   mdio_state_e state;
   logic mdcPrev;
   logic mdcRise;
   logic [5:0] onesCount;
   logic [13:0] header;
   logic [13:0] next_header;
   logic [4:0] bitCount;
   logic [15:0] shift;
   logic hit;

   assign mdcRise = mdc & ~mdcPrev;
   assign next_header = {header[12:0], mdioIn};
   assign hit = next_header[13:12] == aux_phy_pkg::MDIO_ST &&
                next_header[9:5] == phyAddress &&
                next_header[4:0] == aux_phy_pkg::REG_ADDR;

   always_ff @(posedge clk) begin
      if (reset) begin
         mdcPrev <= 1'b0;
      end else begin
         mdcPrev <= mdc;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= MD_PREAMBLE;
         onesCount <= 6'h00;
         header <= 14'h0000;
         bitCount <= 5'h00;
         shift <= 16'h0000;
         mdioOut <= 1'b0;
         mdioOe <= 1'b0;
         wrStrobe <= 1'b0;
         wrData <= 16'h0000;
      end else begin
         wrStrobe <= 1'b0;
         if (mdcRise) begin
            unique case (state)
               MD_PREAMBLE: begin
                  if (mdioIn) begin
                     if (onesCount != aux_phy_pkg::MDIO_PREAMBLE_LEN) begin
                        onesCount <= onesCount + 6'h01;
                     end
                  end else if (onesCount == aux_phy_pkg::MDIO_PREAMBLE_LEN)
                  begin
                     state <= MD_HEADER;
                     header <= 14'h0000;
                     bitCount <= aux_phy_pkg::MDIO_START_COUNT;
                     onesCount <= 6'h00;
                  end else begin
                     onesCount <= 6'h00;
                  end
               end
               MD_HEADER: begin
                  header <= next_header;
                  bitCount <= bitCount + 5'h01;
                  if (bitCount == aux_phy_pkg::MDIO_HDR_LAST) begin
                     bitCount <= 5'h00;
                     state <= MD_PREAMBLE;
                     if (hit && next_header[11:10] == aux_phy_pkg::MDIO_OP_RD)
                     begin
                        state <= MD_READ;
                        shift <= readWord;
                     end else if (hit &&
                        next_header[11:10] == aux_phy_pkg::MDIO_OP_WR) begin
                        state <= MD_WRITE;
                     end
                  end
               end
               MD_READ: begin
                  bitCount <= bitCount + 5'h01;
                  if (bitCount == 5'h00) begin
                     mdioOe <= 1'b1;
                     mdioOut <= 1'b0;
                  end else if (bitCount <= aux_phy_pkg::MDIO_RD_LAST) begin
                     mdioOut <= shift[15];
                     shift <= {shift[14:0], 1'b0};
                  end else begin
                     mdioOe <= 1'b0;
                     mdioOut <= 1'b0;
                     bitCount <= 5'h00;
                     state <= MD_PREAMBLE;
                  end
               end
               MD_WRITE: begin
                  bitCount <= bitCount + 5'h01;
                  if (bitCount >= aux_phy_pkg::MDIO_TA_LEN) begin
                     shift <= {shift[14:0], mdioIn};
                  end
                  if (bitCount == aux_phy_pkg::MDIO_WR_LAST) begin
                     wrStrobe <= 1'b1;
                     wrData <= {shift[14:0], mdioIn};
                     bitCount <= 5'h00;
                     state <= MD_PREAMBLE;
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/aux_phy_autoneg_status.sv ----
// auxiliary negotiation status and control register with its slave
`timescale 1ns/1ps
`default_nettype none
module aux_phy_autoneg_status (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // management pins
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic [4:0] phyAddress,
   // companion register bits
   input wire logic anEnable,
   input wire logic basicCtrlRestart,
   input wire logic basicCtrlIsolate,
   input wire logic miscCfgIsolate,
   // negotiation machine events
   input wire logic anStarted,
   input wire logic anCompleteEvent,
   input wire logic linkFault,
   input wire logic firstAckRx,
   input wire logic ackDetectExit,
   input wire logic txDisable,
   input wire logic hcdValid,
   input wire logic [1:0] hcdMode,
   input wire logic parallelDetect,
   // partner pulses
   input wire logic flpBurstRx,
   input wire logic linkPulseRx,
   // to the negotiation machine and the other registers
   output logic anRestart,
   output logic anCompleteMirror,
   output logic abilityDetectMirror,
   output logic linkPassState,
   // media interface steering
   output logic miiInputIgnore,
   output logic miiDriveEnable,
   output logic linkPulseSuppress
);
   typedef enum logic [1:0] {
      ABL_IDLE = 2'b00,
      ABL_WAIT = 2'b01,
      ABL_DETECT = 2'b10,
      ABL_DONE = 2'b11
   } ability_state_e;

   localparam logic [aux_phy_pkg::TIMER_W-1:0] WAIT_LOAD =
      aux_phy_pkg::TIMER_W'(aux_phy_pkg::ABILITY_WAIT_CYCLES - 1);

   ability_state_e abilityState;
   logic [aux_phy_pkg::TIMER_W-1:0] waitTimer;
   logic wrStrobe;
   logic [15:0] wrData;
   logic [15:0] readWord;
   logic restartReq;
   logic restartPending;
   logic complete;
   logic ackDone;
   logic firstAck;
   logic detach;
   logic [aux_phy_pkg::HCD_COUNT-1:0] hcdFlags;
   logic hcdSet;

   // management frame slave for this address
   mdio_frame_slave u_slave (
      .clk(clk),
      .reset(reset),
      .mdc(mdc),
      .mdioIn(mdioIn),
      .mdioOut(mdioOut),
      .mdioOe(mdioOe),
      .phyAddress(phyAddress),
      .readWord(readWord),
      .wrStrobe(wrStrobe),
      .wrData(wrData)
   );

   // basic control restart shares the path
   assign restartReq = anEnable &&
      ((wrStrobe && wrData[aux_phy_pkg::BIT_RESTART]) || basicCtrlRestart);

   // forced-speed partners never set a flag
   // handshake results only
   assign hcdSet = hcdValid && !parallelDetect && anEnable;

   // two-bit mode code sets one flag
   hcd_result_latch u_hcd (
      .clk(clk),
      .reset(reset),
      .clear(restartReq),
      .setValid(hcdSet),
      .setMode(hcdMode),
      .flags(hcdFlags)
   );

   // restart request held until the machine starts
   // a restart in the start cycle wins
   always_ff @(posedge clk) begin
      if (reset) begin
         restartPending <= 1'b0;
      end else if (restartReq) begin
         restartPending <= 1'b1;
      end else if (anStarted) begin
         restartPending <= 1'b0;
      end
   end

   assign anRestart = restartPending;

   // completion flag
   always_ff @(posedge clk) begin
      if (reset) begin
         complete <= 1'b0;
      // completion sticks until restart, fault or disable
      end else if (anCompleteEvent && anEnable) begin
         complete <= 1'b1;
      end else if (restartReq || linkFault || !anEnable) begin
         complete <= 1'b0;
      end
   end

   // acknowledge-detect exit flag
   always_ff @(posedge clk) begin
      if (reset) begin
         ackDone <= 1'b0;
      end else if (ackDetectExit) begin
         ackDone <= 1'b1;
      end else if (restartReq) begin
         ackDone <= 1'b0;
      end
   end

   // first acknowledge flag
   always_ff @(posedge clk) begin
      if (reset) begin
         firstAck <= 1'b0;
      // first ack held until tx off or restart
      end else if (firstAckRx) begin
         firstAck <= 1'b1;
      end else if (txDisable || restartReq) begin
         firstAck <= 1'b0;
      end
   end

   // ability detect tracking
   always_ff @(posedge clk) begin
      if (reset) begin
         abilityState <= ABL_IDLE;
      end else if (!anEnable || restartReq) begin
         abilityState <= ABL_IDLE;
      end else begin
         unique case (abilityState)
            ABL_IDLE: begin
               if (anStarted) begin
                  abilityState <= ABL_WAIT;
               end
            end
            ABL_WAIT: begin
               if (waitTimer == '0) begin
                  abilityState <= ABL_DETECT;
               end
            end
            ABL_DETECT: begin
               if (flpBurstRx || linkPulseRx) begin
                  abilityState <= ABL_DONE;
               end
            end
            ABL_DONE: begin
               if (anStarted) begin
                  abilityState <= ABL_WAIT;
               end
            end
         endcase
      end
   end

   // fixed delay before ability detect
   always_ff @(posedge clk) begin
      if (reset) begin
         waitTimer <= '0;
      end else if (!anEnable || restartReq) begin
         waitTimer <= '0;
      // load the fixed delay on a start
      end else if (anStarted && (abilityState == ABL_IDLE ||
            abilityState == ABL_DONE)) begin
         waitTimer <= WAIT_LOAD;
      end else if (abilityState == ABL_WAIT && waitTimer != '0) begin
         waitTimer <= waitTimer - 1'b1;
      end
   end

   // detach control bit
   always_ff @(posedge clk) begin
      if (reset) begin
         detach <= aux_phy_pkg::REG_RESET[aux_phy_pkg::BIT_DETACH];
      end else if (wrStrobe) begin
         detach <= wrData[aux_phy_pkg::BIT_DETACH];
      end
   end

   // media steering
   always_ff @(posedge clk) begin
      if (reset) begin
         miiInputIgnore <= 1'b0;
         miiDriveEnable <= 1'b1;
         linkPulseSuppress <= 1'b0;
      end else begin
         // same as basic isolate plus misc config bit
         miiInputIgnore <= detach || basicCtrlIsolate;
         miiDriveEnable <= !(detach || basicCtrlIsolate);
         linkPulseSuppress <= detach || miscCfgIsolate;
      end
   end

   // completion mirror for the other status registers
   always_ff @(posedge clk) begin
      if (reset) begin
         anCompleteMirror <= 1'b0;
      end else begin
         anCompleteMirror <= complete && anEnable;
      end
   end

   // ability detect mirror
   always_ff @(posedge clk) begin
      if (reset) begin
         abilityDetectMirror <= 1'b0;
      end else begin
         abilityDetectMirror <= abilityState == ABL_DETECT;
      end
   end

   // link pass indication
   always_ff @(posedge clk) begin
      if (reset) begin
         linkPassState <= 1'b0;
      end else begin
         // link pass from bits 6 and 7
         linkPassState <= ackDone || (complete && anEnable);
      end
   end

   // register image served at its address
   always_comb begin
      readWord = 16'h0000;
      readWord[aux_phy_pkg::BIT_100_FDX] = hcdFlags[aux_phy_pkg::HCD_100_FDX];
      readWord[aux_phy_pkg::BIT_100_HDX] = hcdFlags[aux_phy_pkg::HCD_100_HDX];
      readWord[aux_phy_pkg::BIT_10_FDX] = hcdFlags[aux_phy_pkg::HCD_10_FDX];
      readWord[aux_phy_pkg::BIT_10_HDX] = hcdFlags[aux_phy_pkg::HCD_10_HDX];
      readWord[aux_phy_pkg::BIT_T4] = 1'b0;
      readWord[aux_phy_pkg::BIT_RESTART] = 1'b0;
      readWord[aux_phy_pkg::BIT_COMPLETE] = complete && anEnable;
      readWord[aux_phy_pkg::BIT_ACK_DONE] = ackDone;
      readWord[aux_phy_pkg::BIT_FIRST_ACK] = firstAck;
      readWord[aux_phy_pkg::BIT_ABILITY] = abilityState == ABL_DETECT;
      readWord[aux_phy_pkg::BIT_DETACH] = detach;
   end
endmodule
`default_nettype wire

// ---- tb/aux_phy_autoneg_status_asserts.sv ----
// assertions on the ports of the auxiliary negotiation status block
`timescale 1ns/1ps
`default_nettype none
module aux_phy_autoneg_status_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // inputs
   input wire logic anEnable,
   input wire logic basicCtrlRestart,
   input wire logic basicCtrlIsolate,
   input wire logic anStarted,
   input wire logic anCompleteEvent,
   input wire logic linkFault,
   input wire logic ackDetectExit,
   input wire logic flpBurstRx,
   input wire logic linkPulseRx,
   // outputs
   input wire logic mdioOe,
   input wire logic anRestart,
   input wire logic anCompleteMirror,
   input wire logic abilityDetectMirror,
   input wire logic linkPassState,
   input wire logic miiInputIgnore,
   input wire logic miiDriveEnable,
   input wire logic linkPulseSuppress
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [8:0] since;
   // cycles since negotiation began, saturating
   always_ff @(posedge clk) begin
      if (reset || anStarted) begin
         since <= 9'h000;
      end else if (since != 9'h1ff) begin
         since <= since + 9'h001;
      end
   end
   chk_reset_quiet: assert property (
      disable iff (1'b0) reset |=> !anRestart && !linkPassState && !mdioOe)
      else $error("outputs active after reset");
   chk_drive_inverse: assert property (
      miiDriveEnable == !miiInputIgnore)
      else $error("mii drive not inverse of ignore");
   chk_detach_suppress: assert property (
      !basicCtrlIsolate ##1 miiInputIgnore |-> linkPulseSuppress)
      else $error("detach without link pulse suppression");
   chk_isolate_follow: assert property (
      basicCtrlIsolate |=> miiInputIgnore)
      else $error("basic isolate not followed");
   chk_restart_basic: assert property (
      basicCtrlRestart && anEnable && !anStarted |=> anRestart)
      else $error("basic restart not taken");
   chk_restart_clear: assert property (
      anStarted && !basicCtrlRestart |=> !anRestart)
      else $error("restart pending after start");
   chk_complete_mirror: assert property (
      anCompleteEvent && anEnable ##1 anEnable |=> anCompleteMirror)
      else $error("completion not mirrored");
   chk_disabled_zero: assert property (
      !anEnable |=> !anCompleteMirror)
      else $error("completion while disabled");
   chk_fault_clear: assert property (
      linkFault && !anCompleteEvent |=> ##1 !anCompleteMirror)
      else $error("completion kept after fault");
   chk_ability_entry: assert property (
      $rose(abilityDetectMirror) |-> since inside {[9'h0f8:9'h0fe]})
      else $error("ability detect entered at wrong time");
   chk_ability_exit: assert property (
      (flpBurstRx || linkPulseRx) && abilityDetectMirror
      |=> ##1 !abilityDetectMirror)
      else $error("ability detect kept after pulses");
   chk_link_pass: assert property (
      ackDetectExit |=> ##1 linkPassState)
      else $error("link pass not raised");
endmodule
bind aux_phy_autoneg_status aux_phy_autoneg_status_asserts u_chk (
   .clk, .reset, .anEnable, .basicCtrlRestart, .basicCtrlIsolate,
   .anStarted, .anCompleteEvent, .linkFault, .ackDetectExit, .flpBurstRx,
   .linkPulseRx, .mdioOe, .anRestart, .anCompleteMirror,
   .abilityDetectMirror, .linkPassState, .miiInputIgnore, .miiDriveEnable,
   .linkPulseSuppress);
`default_nettype wire

// ---- tb/mdio_host_model.sv ----
// management controller model driving the serial management pins
`timescale 1ns/1ps
`default_nettype none
module mdio_host_model (
   // clock
   input wire logic clk,
   // management pins
   output logic mdc,
   output logic mdioLine,
   input wire logic mdioOut,
   input wire logic mdioOe
);
   logic hostBit = 1'b1;
   initial mdc = 1'b0;
   // pull-up level when nobody drives
   assign mdioLine = mdioOe ? mdioOut : hostBit;
   task automatic cyc(input logic b, output logic s);
      @(posedge clk) #1;
      hostBit = b;
      repeat (3) @(posedge clk);
      #1;
      s = mdioLine;
      mdc = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      mdc = 1'b0;
   endtask
   task automatic frame(input logic wr, input logic [4:0] phy,
         input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [63:0] f;
      logic s;
      f = {32'hffffffff, 2'h1, wr ? 2'h1 : 2'h2, phy, ra,
         wr ? 2'h2 : 2'h3, wd};
      for (int i = 63; i >= 0; i--) begin
         cyc(f[i], s);
         if (i < 16) rd[i] = s;
      end
      hostBit = 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_aux_phy_autoneg_status.sv ----
// self-checking bench for the auxiliary negotiation status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("wrong value %s: expected %h, seen %h", what, exp, got); \
      end \
   end
module tb_aux_phy_autoneg_status;
   localparam logic [15:0] DEF = 16'hf9f8;
   localparam logic [8:0] E_RST = 9'h001, E_GO = 9'h002, E_DONE = 9'h004;
   localparam logic [8:0] E_ACK = 9'h008, E_ACKX = 9'h010, E_VAL = 9'h020;
   localparam logic [8:0] E_FLP = 9'h040, E_LP = 9'h080, E_FLT = 9'h100;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic mdc, mdioLine, mdioOut, mdioOe;
   logic [4:0] phy = 5'h05;
   logic anEnable = 1'b1;
   logic iso = 1'b0;
   logic miscIso = 1'b0;
   logic txDis = 1'b0;
   logic parDet = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [8:0] evt = 9'h000;
   logic anRestart, anCompleteMirror, abilityDetectMirror, linkPassState;
   logic miiInputIgnore, miiDriveEnable, linkPulseSuppress;
   logic [15:0] v, w;
   logic [1:0] m;
   int err_count = 0;
   int tests_run = 0;
   aux_phy_autoneg_status dut (.clk(clk), .reset(reset), .mdc(mdc),
      .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .phyAddress(phy), .anEnable(anEnable), .basicCtrlRestart(evt[0]),
      .basicCtrlIsolate(iso), .miscCfgIsolate(miscIso),
      .anStarted(evt[1]), .anCompleteEvent(evt[2]), .linkFault(evt[8]),
      .firstAckRx(evt[3]), .ackDetectExit(evt[4]), .txDisable(txDis),
      .hcdValid(evt[5]), .hcdMode(mode), .parallelDetect(parDet),
      .flpBurstRx(evt[6]), .linkPulseRx(evt[7]), .anRestart(anRestart),
      .anCompleteMirror(anCompleteMirror),
      .abilityDetectMirror(abilityDetectMirror),
      .linkPassState(linkPassState), .miiInputIgnore(miiInputIgnore),
      .miiDriveEnable(miiDriveEnable),
      .linkPulseSuppress(linkPulseSuppress));
   mdio_host_model host (.clk(clk), .mdc(mdc), .mdioLine(mdioLine),
      .mdioOut(mdioOut), .mdioOe(mdioOe));
   initial begin
      forever #2 clk = ~clk;
   end
   function automatic logic [15:0] flag(input logic [1:0] c);
      case (c)
         2'h0: return 16'h0800;
         2'h1: return 16'h1000;
         2'h2: return 16'h2000;
         default: return 16'h8000;
      endcase
   endfunction
   task automatic pulse(input logic [8:0] e);
      @(posedge clk) #1;
      evt = e;
      @(posedge clk) #1;
      evt = 9'h000;
   endtask
   task automatic rd(input logic [4:0] a);
      host.frame(1'b0, phy, a, 16'hffff, v);
   endtask
   task automatic wr(input logic [15:0] d);
      host.frame(1'b1, phy, 5'h1e, d, w);
   endtask
   task automatic steer(input string n, input logic [2:0] e);
      repeat (2) @(posedge clk);
      #1;
      `CHK(n, e, {miiInputIgnore, miiDriveEnable, linkPulseSuppress})
   endtask
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done;
   end
   initial begin
      void'($urandom(32'h50d56164));
      phy = 5'($urandom);
      repeat (6) @(posedge clk);
      #1;
      reset = 1'b0;
      rd(5'h1e);
      `CHK("reset value", 16'h0000, v & DEF)
      rd(5'h1d);
      `CHK("other register", 16'hffff, v)
      $display("test reset ended");
      m = 2'($urandom);
      for (int k = 0; k < 4; k++) begin
         m = m + 2'h1;
         if (k[0]) pulse(E_RST);
         else wr((16'($urandom) & 16'hfe00) | 16'h0100);
         `CHK("restart pending", 1'b1, anRestart)
         pulse(E_GO);
         rd(5'h1e);
         `CHK("after restart", 16'h0010, v & DEF)
         mode = m;
         pulse(E_VAL | E_DONE | E_ACK | E_ACKX | (k[0] ? E_FLP : E_LP));
         rd(5'h1e);
         `CHK("result", flag(m) | 16'h00e0, v & DEF)
      end
      pulse(E_FLT);
      mode = m ^ 2'h1;
      pulse(E_VAL | E_DONE);
      rd(5'h1e);
      `CHK("accumulated", flag(m) | flag(mode) | 16'h00e0, v & DEF)
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      rd(5'h1e);
      `CHK("second reset", 16'h0000, v & DEF)
      $display("test results ended");
      wr(16'h0100);
      pulse(E_GO);
      parDet = 1'b1;
      pulse(E_VAL | E_DONE);
      parDet = 1'b0;
      rd(5'h1e);
      `CHK("parallel detect", 16'h0090, v & DEF)
      pulse(E_LP | E_ACK);
      rd(5'h1e);
      `CHK("first ack", 16'h00a0, v & DEF)
      txDis = 1'b1;
      @(posedge clk) #1;
      txDis = 1'b0;
      rd(5'h1e);
      `CHK("tx disabled", 16'h0080, v & DEF)
      $display("test ack ended");
      anEnable = 1'b0;
      rd(5'h1e);
      `CHK("disabled", 16'h0000, v & DEF)
      wr(16'hffff);
      `CHK("restart ignored", 1'b0, anRestart)
      steer("detach", 3'h5);
      rd(5'h1e);
      `CHK("detach read", 16'h0008, v & DEF)
      wr(16'h0000);
      anEnable = 1'b1;
      iso = 1'b1;
      steer("basic isolate", 3'h4);
      iso = 1'b0;
      miscIso = 1'b1;
      steer("misc isolate", 3'h3);
      miscIso = 1'b0;
      $display("test isolate ended");
      test_done;
   end
endmodule
`default_nettype wire
